// File: rtl/dsrs_device.sv
/*
 * target end: register storage reached from a two-wire bus or a three-wire bus
 * that share the same pins; the select pin picks the protocol.
 * assumes the host's serial clock is slow enough to be sampled by clock_i
 * (at least three system cycles per clock phase).
 */
`timescale 1ns/1ps
module dsrs_device
    import dsrs_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    dsrs_if.device                 bus,
    output logic                   wr_valid_o,
    output logic [IDX_W-1:0]       wr_index_o,
    output logic [DATA_W-1:0]      wr_data_o,
    output logic                   busy_o
);
    logic [2:0]          pins_s;
    logic                scl_s, sda_s, sel_s;
    logic                scl_p, sda_p, sel_p;
    logic                scl_rise, scl_fall, start_det, stop_det;
    dsrs_dev_state_t     state_q;
    logic [3:0]          cnt_q;
    logic [7:0]          shift_q;
    logic [7:0]          byte_in;
    logic [7:0]          tx_q;
    logic [IDX_W-1:0]    index_q;
    logic                rw_q;
    logic                hdr_q;
    logic                done_q;
    logic                ack_in_q;
    logic                sda_out_q;
    logic                sda_oe_q;
    logic [DATA_W-1:0]   mem_q [REG_COUNT];

    // pins cross into the system clock domain
    dsrs_sync #(.W(3), .INIT(3'b111)) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .async_i ({bus.sel, bus.sda, bus.scl}),
        .sync_o  (pins_s)
    );
    assign {sel_s, sda_s, scl_s} = pins_s;

    // previous synchronised levels for edge detection
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            sel_p <= 1'b1;
        end else if (ce_i) begin
            scl_p <= scl_s;
            sda_p <= sda_s;
            sel_p <= sel_s;
        end
    end

    // clock edges and bus conditions
    assign scl_rise  = scl_s & ~scl_p;
    assign scl_fall  = ~scl_s & scl_p;
    assign start_det = sel_s & scl_s & scl_p & sda_p & ~sda_s;
    assign stop_det  = sel_s & scl_s & scl_p & ~sda_p & sda_s;
    assign byte_in   = {shift_q[6:0], sda_s};

    // protocol engine for both buses
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= DS_IDLE;
            cnt_q      <= '0;
            shift_q    <= '0;
            tx_q       <= '0;
            index_q    <= '0;
            rw_q       <= 1'b0;
            hdr_q      <= 1'b0;
            done_q     <= 1'b0;
            ack_in_q   <= 1'b1;
            sda_out_q  <= 1'b1;
            sda_oe_q   <= 1'b0;
            busy_o     <= 1'b0;
            wr_valid_o <= 1'b0;
            wr_index_o <= '0;
            wr_data_o  <= '0;
        end else if (ce_i) begin
            wr_valid_o <= 1'b0;
            if (!sel_s) begin
                // three-wire transfer framed by select low
                busy_o <= 1'b0;
                if (sel_p) begin
                    state_q  <= DS_SPI;
                    cnt_q    <= '0;
                    hdr_q    <= 1'b0;
                    done_q   <= 1'b0;
                    sda_oe_q <= 1'b0;
                end else if (scl_rise) begin
                    shift_q <= byte_in;
                    if (cnt_q == BIT_LAST) begin
                        cnt_q <= '0;
                        if (!hdr_q) begin
                            hdr_q   <= 1'b1;
                            rw_q    <= byte_in[7];
                            index_q <= byte_in[6:0];
                        end else if (!rw_q) begin
                            wr_valid_o <= 1'b1;
                            wr_index_o <= index_q;
                            wr_data_o  <= byte_in;
                            index_q    <= index_q + 7'd1;
                        end else begin
                            done_q <= 1'b1;
                        end
                    end else begin
                        cnt_q <= cnt_q + 4'd1;
                    end
                end else if (scl_fall && hdr_q && rw_q) begin
                    // drive the read byte, msb first, then let go
                    if (done_q) begin
                        sda_oe_q <= 1'b0;
                    end else if (cnt_q == 4'd0) begin
                        sda_out_q <= mem_q[index_q][7];
                        tx_q      <= {mem_q[index_q][6:0], 1'b0};
                        sda_oe_q  <= 1'b1;
                    end else begin
                        sda_out_q <= tx_q[7];
                        tx_q      <= {tx_q[6:0], 1'b0};
                    end
                end
            end else if (!sel_p) begin
                // select released ends any three-wire transfer
                state_q  <= DS_IDLE;
                sda_oe_q <= 1'b0;
            end else if (start_det) begin
                // start or repeated start, index kept
                state_q  <= DS_ADDR;
                cnt_q    <= '0;
                sda_oe_q <= 1'b0;
                busy_o   <= 1'b1;
            end else if (stop_det) begin
                state_q  <= DS_IDLE;
                sda_oe_q <= 1'b0;
                busy_o   <= 1'b0;
            end else if (state_q != DS_IDLE) begin
                if (scl_rise) begin
                    if (cnt_q < ACK_CNT) begin
                        shift_q <= byte_in;
                        cnt_q   <= cnt_q + 4'd1;
                    end else if (cnt_q == ACK_SLOT) begin
                        ack_in_q <= sda_s;                   // host acknowledge level
                    end
                end else if (scl_fall) begin
                    if (cnt_q == ACK_CNT) begin
                        cnt_q     <= ACK_SLOT;
                        sda_out_q <= 1'b0;
                        sda_oe_q  <= 1'b1;
                        case (state_q)
                            DS_ADDR: begin
                                rw_q <= shift_q[0];
                                if (shift_q[7:1] != TARGET_ADDR) begin
                                    state_q  <= DS_IDLE;
                                    sda_oe_q <= 1'b0;
                                end
                            end
                            DS_INDEX: begin
                                index_q <= shift_q[6:0];
                            end
                            DS_WDATA: begin
                                wr_valid_o <= 1'b1;
                                wr_index_o <= index_q;
                                wr_data_o  <= shift_q;
                                index_q    <= index_q + 7'd1;
                            end
                            default: begin
                                sda_oe_q <= 1'b0;
                            end
                        endcase
                    end else if (cnt_q == ACK_SLOT) begin
                        cnt_q    <= '0;
                        sda_oe_q <= 1'b0;
                        case (state_q)
                            DS_ADDR: begin
                                if (rw_q) begin
                                    state_q   <= DS_RDATA;
                                    sda_out_q <= mem_q[index_q][7];
                                    tx_q      <= {mem_q[index_q][6:0], 1'b0};
                                    sda_oe_q  <= 1'b1;
                                    index_q   <= index_q + 7'd1;
                                end else begin
                                    state_q <= DS_INDEX;
                                end
                            end
                            DS_INDEX: begin
                                state_q <= DS_WDATA;
                            end
                            DS_RDATA: begin
                                if (!ack_in_q) begin
                                    sda_out_q <= mem_q[index_q][7];
                                    tx_q      <= {mem_q[index_q][6:0], 1'b0};
                                    sda_oe_q  <= 1'b1;
                                    index_q   <= index_q + 7'd1;
                                end else begin
                                    state_q <= DS_IDLE;
                                end
                            end
                            default: begin
                                state_q <= state_q;
                            end
                        endcase
                    end else if (state_q == DS_RDATA) begin
                        sda_out_q <= tx_q[7];
                        tx_q      <= {tx_q[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // register storage, one entry per index
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                mem_q[i] <= REG_RESET;
            end else if (ce_i && wr_valid_o && wr_index_o == IDX_W'(i)) begin
                mem_q[i] <= wr_data_o;
            end
        end
    end

    // pin drive
    assign bus.dev_sda_o  = sda_out_q;
    assign bus.dev_sda_oe = sda_oe_q;
endmodule : dsrs_device

// File: rtl/dsrs_host.sv
/*
 * host end: runs one single-byte register write or read per command on either bus.
 * assumes the target follows the same pin protocol; the serial clock is made here
 * by dividing clock_i, four quarters per bit.
 */
`timescale 1ns/1ps
module dsrs_host
    import dsrs_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    dsrs_if.host                   bus,
    input  wire logic              cmd_valid_i,
    output logic                   cmd_ready_o,
    input  wire logic              cmd_spi_i,
    input  wire logic              cmd_read_i,
    input  wire logic [IDX_W-1:0]  cmd_index_i,
    input  wire logic [DATA_W-1:0] cmd_wdata_i,
    output logic                   done_o,
    output logic                   nack_o,
    output logic [DATA_W-1:0]      rdata_o
);
    dsrs_host_state_t  state_q;
    dsrs_step_t        kind;
    logic [7:0]        step_byte;
    logic [4:0]        div_q;
    logic [1:0]        qtr_q;
    logic [3:0]        bit_q;
    logic [2:0]        step_q;
    logic              spi_q, read_q, nack_q;
    logic [IDX_W-1:0]  index_q;
    logic [DATA_W-1:0] wdata_q, rx_q;
    logic              tick, last_bit, bit_val;
    logic [2:0]        stop_step;
    logic [1:0]        sda_s;

    // sequence of slots for the latched command
    always_comb begin
        kind      = HK_END;
        step_byte = 8'h00;
        if (spi_q) begin
            case (step_q)
                3'd0: begin kind = HK_WBYTE; step_byte = {read_q, index_q}; end
                3'd1: begin kind = read_q ? HK_RBYTE : HK_WBYTE; step_byte = wdata_q; end
                default: kind = HK_END;
            endcase
        end else begin
            case (step_q)
                3'd0: kind = HK_START;
                3'd1: begin kind = HK_WBYTE; step_byte = {TARGET_ADDR, 1'b0}; end
                3'd2: begin kind = HK_WBYTE; step_byte = {1'b0, index_q}; end
                3'd3: begin
                    kind      = read_q ? HK_START : HK_WBYTE;
                    step_byte = wdata_q;
                end
                3'd4: begin
                    kind      = read_q ? HK_WBYTE : HK_STOP;
                    step_byte = {TARGET_ADDR, 1'b1};
                end
                3'd5: kind = HK_RBYTE;
                3'd6: kind = HK_STOP;
                default: kind = HK_END;
            endcase
        end
    end

    assign tick        = (div_q == QTR_LAST);
    assign last_bit    = bit_q == (spi_q ? BIT_LAST : ACK_CNT);
    assign bit_val     = step_byte[3'(BIT_LAST - bit_q)];
    assign stop_step   = read_q ? 3'd6 : 3'd4;
    assign cmd_ready_o = (state_q == HS_IDLE);

    // data pin sampled through two flops
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_s <= 2'b11;
        end else if (ce_i) begin
            sda_s <= {sda_s[0], bus.sda};
        end
    end

    // quarter-bit divider
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= '0;
        end else if (ce_i) begin
            div_q <= (tick || state_q == HS_IDLE) ? 5'd0 : div_q + 5'd1;
        end
    end

    // slot sequencer and pin drive
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q         <= HS_IDLE;
            qtr_q           <= '0;
            bit_q           <= '0;
            step_q          <= '0;
            spi_q           <= 1'b0;
            read_q          <= 1'b0;
            nack_q          <= 1'b0;
            index_q         <= '0;
            wdata_q         <= '0;
            rx_q            <= '0;
            done_o          <= 1'b0;
            nack_o          <= 1'b0;
            rdata_o         <= '0;
            bus.scl         <= 1'b1;
            bus.sel         <= 1'b1;
            bus.host_sda_o  <= 1'b0;
            bus.host_sda_oe <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (state_q == HS_IDLE) begin
                if (cmd_valid_i) begin
                    state_q <= HS_RUN;
                    spi_q   <= cmd_spi_i;
                    read_q  <= cmd_read_i;
                    index_q <= cmd_index_i;
                    wdata_q <= cmd_wdata_i;
                    nack_q  <= 1'b0;
                    qtr_q   <= '0;
                    bit_q   <= '0;
                    step_q  <= '0;
                    bus.sel <= ~cmd_spi_i;
                end
            end else if (tick) begin
                qtr_q <= qtr_q + 2'd1;
                case (kind)
                    HK_START: begin
                        // also serves as repeated start
                        case (qtr_q)
                            2'd0: bus.host_sda_oe <= 1'b0;
                            2'd1: bus.scl <= 1'b1;
                            2'd2: bus.host_sda_oe <= 1'b1;
                            default: begin bus.scl <= 1'b0; step_q <= step_q + 3'd1; end
                        endcase
                    end
                    HK_STOP: begin
                        case (qtr_q)
                            2'd0: bus.host_sda_oe <= 1'b1;
                            2'd1: bus.scl <= 1'b1;
                            2'd2: bus.host_sda_oe <= 1'b0;
                            default: step_q <= 3'd7;
                        endcase
                    end
                    HK_WBYTE, HK_RBYTE: begin
                        case (qtr_q)
                            2'd0: begin
                                bus.scl <= 1'b0;
                                // acknowledge slot released on writes, nack on the read
                                bus.host_sda_oe <= (kind == HK_WBYTE) && (bit_q < ACK_CNT)
                                                   && !bit_val;
                            end
                            2'd1: bus.scl <= 1'b1;
                            2'd2: begin
                                if (bit_q < ACK_CNT) begin
                                    rx_q <= {rx_q[6:0], sda_s[1]};
                                end else if (kind == HK_WBYTE && sda_s[1]) begin
                                    nack_q <= 1'b1;
                                end
                            end
                            default: begin
                                bus.scl <= spi_q;
                                if (last_bit) begin
                                    bit_q  <= '0;
                                    step_q <= (nack_q || (kind == HK_WBYTE && !spi_q
                                               && sda_s[1])) ? stop_step : step_q + 3'd1;
                                end else begin
                                    bit_q <= bit_q + 4'd1;
                                end
                            end
                        endcase
                    end
                    default: begin
                        bus.scl         <= 1'b1;
                        bus.sel         <= 1'b1;             // ends a three-wire frame
                        bus.host_sda_oe <= 1'b0;
                        state_q         <= HS_IDLE;
                        done_o          <= 1'b1;
                        nack_o          <= nack_q;
                        rdata_o         <= rx_q;
                    end
                endcase
            end
        end
    end
endmodule : dsrs_host

// File: rtl/dsrs_if.sv
/*
 * pins shared by the host and the slave: serial clock, data and select.
 * data is resolved here: any enabled driver that drives low pulls it low,
 * otherwise the external pull-up holds it high.
 */
`timescale 1ns/1ps
interface dsrs_if;
    logic scl;          // serial clock, also the three_wire_clock
    logic sel;          // high selects two-wire, low frames a three-wire transfer
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;          // resolved three_wire_data_io / two-wire data level

    // wired level with pull-up
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport device (input scl, input sel, input sda, output dev_sda_o, output dev_sda_oe);
    modport host   (output scl, output sel, output host_sda_o, output host_sda_oe, input sda);
endinterface : dsrs_if

// File: rtl/dsrs_pkg.sv
/*
 * shared constants and types for the dual serial register slave and its host.
 * assumes a 50 MHz system clock on both ends.
 */
package dsrs_pkg;
    localparam int          CLK_NS        = 20;          // system clock period
    localparam logic [6:0]  TARGET_ADDR   = 7'h5A;       // fixed target bus address 1011010
    localparam int          IDX_W         = 7;           // register index width
    localparam int          DATA_W        = 8;           // register width
    localparam int          REG_COUNT     = 128;         // index space
    localparam logic [3:0]  BIT_LAST      = 4'h7;        // last bit of a byte
    localparam logic [3:0]  ACK_CNT       = 4'h8;        // bits counted before acknowledge
    localparam logic [3:0]  ACK_SLOT      = 4'h9;        // acknowledge clock in progress
    localparam logic [7:0]  REG_RESET     = 8'h00;       // storage reset value
    // host serial clock quarter period; four quarters make one bit
    localparam int          QTR_NS        = 260;
    localparam int          QTR_CYC       = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0]  QTR_LAST      = 5'(QTR_CYC - 1);

    typedef enum logic [2:0] {
        DS_IDLE, DS_ADDR, DS_INDEX, DS_WDATA, DS_RDATA, DS_SPI
    } dsrs_dev_state_t;

    typedef enum logic [2:0] {
        HK_START, HK_WBYTE, HK_RBYTE, HK_STOP, HK_END
    } dsrs_step_t;

    typedef enum logic {
        HS_IDLE, HS_RUN
    } dsrs_host_state_t;
endpackage : dsrs_pkg

// File: rtl/dsrs_sync.sv
/*
 * two flip-flop synchroniser for a group of pin levels, frozen by the enable.
 * assumes inputs are asynchronous to clock_i; the first stage feeds only the second.
 */
`timescale 1ns/1ps
module dsrs_sync #(
    parameter int             W    = 3,
    parameter logic [W-1:0]   INIT = '1
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // two stages in series
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= INIT;
            sync_o <= INIT;
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : dsrs_sync

// File: tb/dsrs_properties.sv
/* pin checker for the shared serial lines between host and device.
   assumes the lines are seen through the 50 MHz system clock of both ends. */
`timescale 1ns/1ps
module dsrs_properties (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic scl,
    input wire logic sel,
    input wire logic sda,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe
);
    logic [4:0] rise_q;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // counts serial clock rises inside one three-wire frame
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rise_q <= 5'h00;
        end else if (sel) begin
            rise_q <= 5'h00;
        end else if ($rose(scl)) begin
            rise_q <= rise_q + 5'h01;
        end
    end

    // two-wire only: the device lets go of a three-wire read a few cycles after select rises
    ack_stable_a: assert property (sel && $past(sel, 8) && scl && $past(scl)
        |-> $stable(dev_sda_oe) && $stable(dev_sda_o))
        else $error("device data changed while clock high");
    no_fight_a: assert property (!(host_sda_oe && dev_sda_oe && dev_sda_o))
        else $error("device drives high while host pulls low");
    frame_open_a: assert property ($fell(sel) |-> scl)
        else $error("frame opened with clock low");
    frame_count_a: assert property ($rose(sel) |-> rise_q == 5'h10)
        else $error("three-wire frame not 16 clocks");
    frame_release_a: assert property ($rose(sel) |-> ##[0:6] !dev_sda_oe)
        else $error("device kept data after frame end");
    start_free_a: assert property (sel && scl && $fell(sda) |-> !dev_sda_oe)
        else $error("device drives data at start");
    stop_idle_a: assert property (sel && scl && $rose(sda) |-> ##[1:8] !dev_sda_oe)
        else $error("device busy after stop");
    lines_high_a: assert property (sel && scl && $rose(sda) |=> (scl && sda) [*2])
        else $error("lines not high after stop");
endmodule : dsrs_properties

// File: tb/tb.sv
/* bench: host and device joined by the shared pins, a command table, then a reset case.
   assumes the host runs one single-byte command at a time. */
`timescale 1ns/1ps
module tb;
    import dsrs_pkg::*;
    `define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
        $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
    logic        clock_i = 1'h0;
    logic        rst_n_i = 1'h0;
    logic        valid = 1'h0, spi = 1'h0, rd = 1'h0, ready, done, nack, wr_v, busy;
    logic        ce = 1'h1, hold = 1'h0;
    logic [6:0]  idx = 7'h00, wr_idx, got_idx = 7'h00;
    logic [7:0]  wdat = 8'h00, rdat, wr_dat, got_dat = 8'h00;
    int          failures = 0, checked = 0, cycles = 0;
    // mode byte: bit1 three-wire, bit0 read; then index, write byte, expected read byte
    // every index written here is ordinary storage, none reserved
    logic [31:0] rows [8] = '{32'h0000_A500, 32'h0100_00A5, 32'h027F_3C00, 32'h037F_003C,
                              32'h017F_003C, 32'h0300_00A5, 32'h0041_FF00, 32'h0341_00FF};
    dsrs_if bus ();
    dsrs_host dsrs_host_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .bus(bus),
        .cmd_valid_i(valid), .cmd_ready_o(ready), .cmd_spi_i(spi), .cmd_read_i(rd),
        .cmd_index_i(idx), .cmd_wdata_i(wdat), .done_o(done), .nack_o(nack), .rdata_o(rdat));
    dsrs_device dsrs_device_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .bus(bus),
        .wr_valid_o(wr_v), .wr_index_o(wr_idx), .wr_data_o(wr_dat), .busy_o(busy));
    dsrs_properties dsrs_properties_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl(bus.scl),
        .sel(bus.sel), .sda(bus.sda), .host_sda_oe(bus.host_sda_oe),
        .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));

    // system clock, 20 ns period
    always #10 clock_i = ~clock_i;
    // keeps the last stored index and byte
    always @(negedge clock_i) if (wr_v === 1'h1) begin got_idx = wr_idx; got_dat = wr_dat; end
    // cuts a hang short
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            end_sim();
        end
    end

    task end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic run(input logic [31:0] r);
        logic [2:0] pins;
        @(posedge clock_i);
        spi <= r[25];
        rd <= r[24];
        idx <= r[22:16];
        wdat <= r[15:8];
        valid <= 1'h1;
        do @(negedge clock_i); while (ready !== 1'h1);
        @(posedge clock_i);
        valid <= 1'h0;
        // mid-command: two-wire bus busy, three-wire never
        repeat (100) @(negedge clock_i);
        `CHK(busy, !r[25])
        if (hold) begin
            // enable low freezes both ends: pins and command state stand still
            @(posedge clock_i);
            ce <= 1'h0;
            @(negedge clock_i);
            pins = {bus.scl, bus.sel, bus.sda};
            repeat (60) @(negedge clock_i);
            `CHK({bus.scl, bus.sel, bus.sda}, pins)
            `CHK(ready, 1'h0)
            @(posedge clock_i);
            ce <= 1'h1;
        end
        do @(negedge clock_i); while (done !== 1'h1);
        if (r[24]) `CHK(rdat, r[7:0])
        if (!r[24]) `CHK(got_idx, r[22:16])
        if (!r[24]) `CHK(got_dat, r[15:8])
        if (!r[25]) `CHK(nack, 1'h0)
        `CHK(busy, 1'h0)
        $display("command %h done", r);
    endtask : run

    initial begin
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'h1;
        repeat (5) @(posedge clock_i);
        for (int i = 0; i < 8; i++) run(rows[i]);
        // reset after the command table parks the pins and clears storage
        @(posedge clock_i);
        rst_n_i <= 1'h0;
        @(posedge clock_i);
        rst_n_i <= 1'h1;
        @(negedge clock_i);
        `CHK({bus.scl, bus.sel, bus.sda}, 3'h7)
        repeat (5) @(posedge clock_i);
        hold <= 1'h1;
        run(32'h037F_0000);
        end_sim();
    end
endmodule : tb
